/* include/alm_defines.vh */
`ifndef ALM_DEFINES_VH
`define ALM_DEFINES_VH

// Byte offsets of the registers, aligned to 64-bit words.
`define ALM_OFS_INFO      16'h0908
`define ALM_OFS_OVERRIDE  16'h0980
`define ALM_OFS_MAP0      16'h1F00
`define ALM_OFS_MAP1      16'h1F08
`define ALM_OFS_MAP2      16'h1F10
`define ALM_OFS_MAP3      16'h1F18

// Field layout.
`define ALM_INFO_DEPTH_W  10
`define ALM_OVR_LINK_BIT  1
`define ALM_FIELD_W       2
`define ALM_AGENTS        32
`define ALM_AGENTS_PER    8

// Reset values.
`define ALM_FIELD_RST     2'h0
`define ALM_GRANT_RST     1'b0
`define ALM_DEPTH_DEFAULT 10'h040

`endif

/* design/alm_agent_link_map.v */
`include "alm_defines.vh"

module alm_agent_link_map #(
  parameter [`ALM_INFO_DEPTH_W-1:0] PASS_BUF_DEPTH = `ALM_DEPTH_DEFAULT
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [7:0]  wb_sel_i,
  input  wire [63:0] wb_dat_i,
  input  wire        secureAccess,
  output reg         wb_ack_o,
  output reg  [63:0] wb_dat_o,
  output reg  [63:0] linkSelect,
  output reg         linkGrant
);

  localparam [1:0] WORD_MAP0 = 2'h0;
  localparam [1:0] WORD_MAP1 = 2'h1;
  localparam [1:0] WORD_MAP2 = 2'h2;
  localparam [1:0] WORD_MAP3 = 2'h3;

  localparam [1:0] REGION_NONE = 2'h0;
  localparam [1:0] REGION_INFO = 2'h1;
  localparam [1:0] REGION_OVR  = 2'h2;
  localparam [1:0] REGION_MAP  = 2'h3;

  // True when a byte address falls inside the 64-bit word at the given offset.
  function hitWord;
    input [15:0] adr;
    input [15:0] ofs;
    begin
      hitWord = (adr[15:3] == ofs[15:3]);
    end
  endfunction

  // Places eight 2-bit link selects at the bottom of their byte lanes.
  // Every other bit of the word reads as zero.
  function [63:0] spreadFields;
    input [15:0] fields;
    begin
      spreadFields        = 64'h0000000000000000;
      spreadFields[1:0]   = fields[1:0];
      spreadFields[9:8]   = fields[3:2];
      spreadFields[17:16] = fields[5:4];
      spreadFields[25:24] = fields[7:6];
      spreadFields[33:32] = fields[9:8];
      spreadFields[41:40] = fields[11:10];
      spreadFields[49:48] = fields[13:12];
      spreadFields[57:56] = fields[15:14];
    end
  endfunction

  // Takes the enabled byte lanes of a write into eight stored link selects.
  // Only the two low bits of a lane are kept; the reserved bits are dropped.
  function [15:0] mergeFields;
    input [15:0] oldFields;
    input [63:0] data;
    input [7:0]  sel;
    begin
      mergeFields = oldFields;
      if (sel[0]) begin
        mergeFields[1:0] = data[1:0];
      end
      if (sel[1]) begin
        mergeFields[3:2] = data[9:8];
      end
      if (sel[2]) begin
        mergeFields[5:4] = data[17:16];
      end
      if (sel[3]) begin
        mergeFields[7:6] = data[25:24];
      end
      if (sel[4]) begin
        mergeFields[9:8] = data[33:32];
      end
      if (sel[5]) begin
        mergeFields[11:10] = data[41:40];
      end
      if (sel[6]) begin
        mergeFields[13:12] = data[49:48];
      end
      if (sel[7]) begin
        mergeFields[15:14] = data[57:56];
      end
    end
  endfunction

  wire        request;
  wire        writeReq;
  wire [1:0]  mapIndex;
  wire        hitMap0;
  wire        hitMap1;
  wire        hitMap2;
  wire        hitMap3;
  wire        hitMap;
  wire        hitInfo;
  wire        hitOvr;
  wire        mapOk;
  wire        ovrOk;
  wire        writeMap;
  wire        writeOvr;

  reg  [1:0]  accessRegion;
  reg  [15:0] selectedWord;
  reg  [63:0] next_readData;
  reg  [63:0] next_linkSelect;
  reg         next_linkGrant;

  // A request held past its acknowledge is not taken a second time.
  assign request  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign writeReq = request & wb_we_i;
  assign mapIndex = wb_adr_i[4:3];

  assign hitMap0 = hitWord(wb_adr_i, `ALM_OFS_MAP0);
  assign hitMap1 = hitWord(wb_adr_i, `ALM_OFS_MAP1);
  assign hitMap2 = hitWord(wb_adr_i, `ALM_OFS_MAP2);
  assign hitMap3 = hitWord(wb_adr_i, `ALM_OFS_MAP3);
  assign hitMap  = hitMap0 | hitMap1 | hitMap2 | hitMap3;
  assign hitInfo = hitWord(wb_adr_i, `ALM_OFS_INFO);
  assign hitOvr  = hitWord(wb_adr_i, `ALM_OFS_OVERRIDE);

  // The override word itself stays Secure-only; its grant opens the map words.
  assign ovrOk = secureAccess;
  assign mapOk = secureAccess | linkGrant;

  // The information word has no write path, so writes to it do nothing.
  assign writeMap = writeReq & hitMap & mapOk;
  assign writeOvr = writeReq & hitOvr & ovrOk & wb_sel_i[0];

  // Sorts the address into the kind of word it selects.
  always @* begin
    accessRegion = REGION_NONE;
    if (hitInfo) begin
      accessRegion = REGION_INFO;
    end else if (hitOvr) begin
      accessRegion = REGION_OVR;
    end else if (hitMap) begin
      accessRegion = REGION_MAP;
    end
  end

  // Picks the eight stored link selects of the addressed map word.
  always @* begin
    selectedWord = 16'h0000;
    case (mapIndex)
      WORD_MAP0: begin
        selectedWord = linkSelect[15:0];
      end
      WORD_MAP1: begin
        selectedWord = linkSelect[31:16];
      end
      WORD_MAP2: begin
        selectedWord = linkSelect[47:32];
      end
      WORD_MAP3: begin
        selectedWord = linkSelect[63:48];
      end
      default: begin
        selectedWord = 16'h0000;
      end
    endcase
  end

  // Refused and unmapped reads return zero but are still answered.
  always @* begin
    next_readData = 64'h0000000000000000;
    case (accessRegion)
      REGION_INFO: begin
        next_readData[`ALM_INFO_DEPTH_W-1:0] = PASS_BUF_DEPTH;
      end
      REGION_OVR: begin
        if (ovrOk) begin
          next_readData[`ALM_OVR_LINK_BIT] = linkGrant;
        end
      end
      REGION_MAP: begin
        if (mapOk) begin
          next_readData = spreadFields(selectedWord);
        end
      end
      default: begin
        next_readData = 64'h0000000000000000;
      end
    endcase
  end

  always @* begin
    next_linkSelect = linkSelect;
    if (writeMap) begin
      case (mapIndex)
        WORD_MAP0: begin
          next_linkSelect[15:0] = mergeFields(linkSelect[15:0], wb_dat_i, wb_sel_i);
        end
        WORD_MAP1: begin
          next_linkSelect[31:16] = mergeFields(linkSelect[31:16], wb_dat_i, wb_sel_i);
        end
        WORD_MAP2: begin
          next_linkSelect[47:32] = mergeFields(linkSelect[47:32], wb_dat_i, wb_sel_i);
        end
        WORD_MAP3: begin
          next_linkSelect[63:48] = mergeFields(linkSelect[63:48], wb_dat_i, wb_sel_i);
        end
        default: begin
          next_linkSelect = linkSelect;
        end
      endcase
    end
  end

  always @* begin
    next_linkGrant = linkGrant;
    if (writeOvr) begin
      next_linkGrant = wb_dat_i[`ALM_OVR_LINK_BIT];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      // Every taken request is answered one cycle later, refused or not.
      wb_ack_o <= request;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 64'h0000000000000000;
    end else if (request) begin
      wb_dat_o <= next_readData;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      linkSelect <= {`ALM_AGENTS{`ALM_FIELD_RST}};
    end else begin
      linkSelect <= next_linkSelect;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      linkGrant <= `ALM_GRANT_RST;
    end else begin
      linkGrant <= next_linkGrant;
    end
  end

endmodule // alm_agent_link_map

/* verification/alm_agent_link_map_asserts.sv */
module alm_agent_link_map_chk (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic        secureAccess,
  input wire logic        wb_ack_o,
  input wire logic [63:0] wb_dat_o,
  input wire logic [63:0] linkSelect,
  input wire logic        linkGrant
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge sys_clk);
  endclocking

  logic taken;
  logic mapAddr;
  logic infoAddr;
  logic ovrAddr;

  assign taken    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign mapAddr  = (wb_adr_i[15:5] == 11'h0F8);
  assign infoAddr = (wb_adr_i[15:3] == 13'h0121);
  assign ovrAddr  = (wb_adr_i[15:3] == 13'h0130);

  a_reset_clears: assert property (sys_rst |=> linkSelect == 64'h0 && !linkGrant && !wb_ack_o)
    else $error("Reset left a link select, the grant or ack set.");
  a_ack_follows: assert property (disable iff (sys_rst) taken |=> wb_ack_o)
    else $error("A taken request was not acknowledged.");
  a_ack_single: assert property (disable iff (sys_rst) wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge stood for more than one cycle.");
  a_map_reserved: assert property (disable iff (sys_rst) taken && !wb_we_i && mapAddr |=> (wb_dat_o & 64'hFCFCFCFCFCFCFCFC) == 64'h0)
    else $error("A reserved bit of a map word read as one.");
  a_info_upper: assert property (disable iff (sys_rst) taken && !wb_we_i && infoAddr |=> wb_dat_o[63:10] == 54'h0)
    else $error("An upper bit of the information word read as one.");
  a_ns_refused: assert property (disable iff (sys_rst) taken && wb_we_i && mapAddr && !secureAccess && !linkGrant |=> $stable(linkSelect))
    else $error("A Non-secure write changed the map without the grant.");
  a_ns_grant_kept: assert property (disable iff (sys_rst) taken && wb_we_i && ovrAddr && !secureAccess |=> $stable(linkGrant))
    else $error("A Non-secure write changed the grant.");
  a_info_ro: assert property (disable iff (sys_rst) taken && wb_we_i && infoAddr |=> $stable(linkSelect) && $stable(linkGrant))
    else $error("A write to the information word changed state.");

  c_map_write: cover property (disable iff (sys_rst) taken && wb_we_i && mapAddr && secureAccess);
  c_ns_refused: cover property (disable iff (sys_rst) taken && mapAddr && !secureAccess && !linkGrant);
  c_ns_granted: cover property (disable iff (sys_rst) taken && mapAddr && !secureAccess && linkGrant);
endmodule // alm_agent_link_map_chk

bind alm_agent_link_map alm_agent_link_map_chk uChk (.*);

/* verification/alm_agent_link_map_tb.sv */
`include "alm_defines.vh"

module alm_agent_link_map_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic         sys_clk      = 1'b0;
  logic         sys_rst      = 1'b1;
  logic         wb_cyc_i     = 1'b0;
  logic         wb_we_i      = 1'b0;
  logic [15:0]  wb_adr_i     = 16'h0000;
  logic [7:0]   wb_sel_i     = 8'hFF;
  logic [63:0]  wb_dat_i     = 64'h0000000000000000;
  logic         secureAccess = 1'b1;
  logic         wb_stb_i;
  logic         wb_ack_o;
  logic [63:0]  wb_dat_o;
  logic [63:0]  linkSelect;
  logic         linkGrant;
  logic [63:0]  readValue;
  int           num_errors   = 0;
  int           total_checks = 0;
  int           cycleCount   = 0;

  // Each row: address, write data, and what reading the word back must give.
  logic [143:0] rows [6] = '{
    {16'h1F18, 64'hFFFFFFFFFFFFFFFF, 64'h0303030303030303},
    {16'h0908, 64'hFFFFFFFFFFFFFFFF, {54'h0, `ALM_DEPTH_DEFAULT}},
    {16'h1F08, 64'h0706050403020100, 64'h0302010003020100},
    {16'h1F10, 64'h5555555555555555, 64'h0101010101010101},
    {16'h0980, 64'h0000000000000000, 64'h0000000000000000},
    {16'h1F20, 64'hFFFFFFFFFFFFFFFF, 64'h0000000000000000}
  };

  assign wb_stb_i = wb_cyc_i;

  alm_agent_link_map uut (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .secureAccess (secureAccess),
    .wb_ack_o     (wb_ack_o),
    .wb_dat_o     (wb_dat_o),
    .linkSelect   (linkSelect),
    .linkGrant    (linkGrant)
  );

  initial begin
    forever begin
      #12.5 sys_clk = ~sys_clk;
    end
  end

  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount >= 2000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] expected);
    total_checks++;
    if (seen !== expected) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  // Classic single cycle: hold the request until ack is sampled high.
  task automatic bus(input logic write, input logic [15:0] adr, input logic [63:0] data);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_we_i  <= write;
    wb_adr_i <= adr;
    wb_dat_i <= data;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    readValue = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask

  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk(linkSelect, 64'h0);
    chk({63'h0, linkGrant}, 64'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][143:128], rows[i][127:64]);
      bus(1'b0, rows[i][143:128], 64'h0);
      chk(readValue, rows[i][63:0]);
    end
    chk(linkSelect, {16'hFFFF, 16'h5555, 16'hE4E4, 16'h0000});
    // Non-secure accesses are refused while the grant is clear.
    secureAccess <= 1'b0;
    bus(1'b1, 16'h1F00, 64'hFFFFFFFFFFFFFFFF);
    chk(linkSelect, {16'hFFFF, 16'h5555, 16'hE4E4, 16'h0000});
    bus(1'b0, 16'h1F18, 64'h0);
    chk(readValue, 64'h0);
    bus(1'b1, 16'h0980, 64'h2);
    chk({63'h0, linkGrant}, 64'h0);
    // Only the enabled byte lane of a write lands.
    secureAccess <= 1'b1;
    wb_sel_i <= 8'h01;
    bus(1'b1, 16'h1F00, 64'hFFFFFFFFFFFFFFFF);
    chk({48'h0, linkSelect[15:0]}, 64'h0003);
    wb_sel_i <= 8'hFF;
    bus(1'b1, 16'h0980, 64'h2);
    chk({63'h0, linkGrant}, 64'h1);
    bus(1'b0, 16'h0980, 64'h0);
    chk(readValue, 64'h2);
    secureAccess <= 1'b0;
    bus(1'b1, 16'h1F00, 64'hFFFFFFFFFFFFFFFF);
    chk({48'h0, linkSelect[15:0]}, 64'hFFFF);
    bus(1'b0, 16'h1F00, 64'h0);
    chk(readValue, 64'h0303030303030303);
    bus(1'b0, 16'h0980, 64'h0);
    chk(readValue, 64'h0);
    // A reset in mid-run clears the map, the grant and ack.
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk(linkSelect, 64'h0);
    chk({63'h0, linkGrant}, 64'h0);
    chk({63'h0, wb_ack_o}, 64'h0);
    secureAccess <= 1'b1;
    bus(1'b0, 16'h1F18, 64'h0);
    chk(readValue, 64'h0);
    finish_test();
  end
endmodule // alm_agent_link_map_tb
